// *** include/fti_regs.vh ***
// register map, field positions and timing constants for the fan monitor
`ifndef FTI_REGS_VH
`define FTI_REGS_VH

// register offsets (byte addresses on the plain register port)
`define FTI_CFG_ADDR        8'h00
`define FTI_DIVID_ADDR      8'h04
`define FTI_FAN_A_VAL_ADDR  8'h08
`define FTI_FAN_B_VAL_ADDR  8'h0C
`define FTI_FAN_A_LIM_ADDR  8'h10
`define FTI_FAN_B_LIM_ADDR  8'h14
`define FTI_STAT_ADDR       8'h18
`define FTI_MASK_ADDR       8'h1C
`define FTI_INTR_CLR_ADDR   8'h20
`define FTI_STAT_MIR_ADDR   8'h24

// configuration register fields
`define FTI_CFG_START       0
`define FTI_CFG_INT_EN      1
`define FTI_CFG_INT_CLR     3

// divisor register: fan a in bits 5:4, fan b in bits 7:6
`define FTI_DIV_A_LSB       4
`define FTI_DIV_B_LSB       6
`define FTI_DIV_RESET       4'h5

// status bits
`define FTI_STAT_FAN_A      0
`define FTI_STAT_FAN_B      1
`define FTI_STAT_INTRUSION  2

// intrusion clear register bit
`define FTI_ICLR_BIT        7

// reset values
`define FTI_LIM_RESET       8'hFF
`define FTI_MASK_RESET      8'h00

// timing
`define FTI_OSC_HZ          22500
`define FTI_CLK_HZ          100000000
`define FTI_OSC_DIV         (`FTI_CLK_HZ / `FTI_OSC_HZ)
`define FTI_ICLR_MS         20
`define FTI_ICLR_CYC        ((`FTI_CLK_HZ / 1000) * `FTI_ICLR_MS)

`endif

// *** hw/fti_fan_counter.v ***
// period counter for one fan tachometer: three rising edges, saturating
`timescale 1ns/1ps
module fti_fan_counter #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // control
  input  wire             go,
  input  wire             oscTick,
  input  wire [1:0]       divSel,
  input  wire             tachRise,
  // result
  output reg              done,
  output reg  [WIDTH-1:0] count
);

  localparam [WIDTH-1:0] FULL = {WIDTH{1'b1}};

  reg [1:0] edgeCnt;
  reg       running;
  reg [2:0] preCnt;
  reg [2:0] preMax;

  // prescaler terminal value from the 2-bit divisor code
  always @* begin
    case (divSel)
      2'd0:    preMax = 3'd0;
      2'd1:    preMax = 3'd1;
      2'd2:    preMax = 3'd3;
      default: preMax = 3'd7;
    endcase
  end

  // arm on go, count between first and third rising edge
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edgeCnt <= 2'd0;
      running <= 1'b0;
      preCnt  <= 3'd0;
      count   <= {WIDTH{1'b0}};
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go) begin
        edgeCnt <= 2'd0;
        running <= 1'b1;
        preCnt  <= 3'd0;
        count   <= {WIDTH{1'b0}};
      end else if (running) begin
        if (tachRise) begin
          edgeCnt <= edgeCnt + 2'd1;
          if (edgeCnt == 2'd2) begin
            running <= 1'b0;
            done    <= 1'b1;
          end
        end
        // prescaled oscillator gated while between edges
        if (edgeCnt != 2'd0 && oscTick) begin
          if (preCnt == preMax) begin
            preCnt <= 3'd0;
            if (count != FULL)
              count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
          end else begin
            preCnt <= preCnt + 3'd1;
          end
        end
        // full scale ends the measurement early
        if (count == FULL && !(tachRise && edgeCnt == 2'd2)) begin
          running <= 1'b0;
          done    <= 1'b1;
        end
      end
    end
  end

endmodule // fti_fan_counter

// *** hw/fti_fan_monitor.v ***
// fan period monitor with limit status, interrupt and intrusion clear
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "fti_regs.vh"

// Overview of operation
// - gated oscillator period count, eight bits
// - start bit set, clear bit low starts
// - count from rising edge to second next
// - fans in turn, end at full scale
// - completed count stored, always readable
// - prescaler 1/2/4/8, default divide two
// - divisors in upper nibble of id register
// - fan fault when count exceeds limit
// - fan and analog start on same command
// - intrusion level raises interrupt status
// - intrusion status holds while input high
// - clear bit pulls pin low 20 ms
// - new value sets or clears status bit
// - mask bit one blocks status bit
// - unmasked status ORed to low interrupt
// - interrupt needs enable high, clear low
// - clear bit drops output, status kept
// - status read returns then clears
module fti_fan_monitor #(
  parameter        WIDTH     = 8,
  parameter [31:0] OSC_DIV   = `FTI_OSC_DIV,
  parameter [31:0] ICLR_CYC  = `FTI_ICLR_CYC
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // register port
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdData,
  // fan and voltage id inputs
  input  wire       tach_in_a,
  input  wire       tach_in_b,
  input  wire [3:0] voltage_id_low,
  // intrusion open-drain pin
  input  wire       intrusion_pin_in,
  output reg        intrusion_pin_out,
  output reg        intrusion_pin_oe,
  // interrupt and analog start
  output reg        int_n,
  output reg        analogStart
);

  localparam ST_IDLE = 3'b001;
  localparam ST_FANA = 3'b010;
  localparam ST_FANB = 3'b100;

  // sequencer state and host registers
  reg [2:0]  state;
  reg [7:0]  cfg;
  reg [3:0]  divSel;

  // measured values and their limits
  reg [7:0]  valA;
  reg [7:0]  valB;
  reg [7:0]  limA;
  reg [7:0]  limB;

  // status, its read-only mirror and the mask
  reg [2:0]  stat;
  reg [2:0]  statMir;
  reg [2:0]  mask;

  // intrusion pulse timer
  reg        iclrBit;
  reg [31:0] iclrCnt;

  // oscillator divider and tach edge history
  reg [31:0] oscCnt;
  reg        oscTick;
  reg        tachAq;
  reg        tachBq;

  // counter handshakes and results
  reg        goA;
  reg        goB;
  wire       doneA;
  wire       doneB;
  wire [7:0] cntA;
  wire [7:0] cntB;

  // register port address match, used by the config write, status read and intrusion clear decoders
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  wire running = cfg[`FTI_CFG_START] & ~cfg[`FTI_CFG_INT_CLR];
  wire wrCfg   = regWr && hit(regAddr, `FTI_CFG_ADDR);
  wire rdStat  = regRd && hit(regAddr, `FTI_STAT_ADDR);
  wire wrIclr  = regWr && hit(regAddr, `FTI_INTR_CLR_ADDR);

  // fault test: period counts, so a larger count means slower fan
  function fault;
    input [7:0] val;
    input [7:0] lim;
    begin
      fault = val > lim;
    end
  endfunction

  // 22.5 kHz tick from the core clock
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oscCnt  <= 32'd0;
      oscTick <= 1'b0;
    end else begin
      oscTick <= (oscCnt == OSC_DIV - 32'd1);
      if (oscCnt == OSC_DIV - 32'd1)
        oscCnt <= 32'd0;
      else
        oscCnt <= oscCnt + 32'd1;
    end
  end

  // previous tach levels for edge detection
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tachAq <= 1'b0;
      tachBq <= 1'b0;
    end else begin
      tachAq <= tach_in_a;
      tachBq <= tach_in_b;
    end
  end

  // one period counter per fan; each idles until its go pulse
  fti_fan_counter #(.WIDTH(WIDTH)) uCntA (
    .core_clk (core_clk),
    .rst      (rst),
    .go       (goA),
    .oscTick  (oscTick),
    .divSel   (divSel[1:0]),
    .tachRise (tach_in_a & ~tachAq),
    .done     (doneA),
    .count    (cntA)
  );

  fti_fan_counter #(.WIDTH(WIDTH)) uCntB (
    .core_clk (core_clk),
    .rst      (rst),
    .go       (goB),
    .oscTick  (oscTick),
    .divSel   (divSel[3:2]),
    .tachRise (tach_in_b & ~tachBq),
    .done     (doneB),
    .count    (cntB)
  );

  // fan sequencer: a then b, looping while running
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state       <= ST_IDLE;
      goA         <= 1'b0;
      goB         <= 1'b0;
      analogStart <= 1'b0;
    end else begin
      goA         <= 1'b0;
      goB         <= 1'b0;
      analogStart <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (running) begin
            state       <= ST_FANA;
            goA         <= 1'b1;
            analogStart <= 1'b1;
          end
        end
        ST_FANA: begin
          if (!running)
            state <= ST_IDLE;
          else if (doneA) begin
            state <= ST_FANB;
            goB   <= 1'b1;
          end
        end
        ST_FANB: begin
          if (!running)
            state <= ST_IDLE;
          else if (doneB) begin
            state <= ST_FANA;
            goA   <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // host-writable configuration, divisor, limit and mask registers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg    <= 8'h00;
      divSel <= `FTI_DIV_RESET;
      limA   <= `FTI_LIM_RESET;
      limB   <= `FTI_LIM_RESET;
      mask   <= 3'b000;
    end else begin
      if (wrCfg)
        cfg <= regWrData;
      if (regWr) begin
        case (regAddr)
          `FTI_DIVID_ADDR:     divSel <= regWrData[7:4];
          `FTI_FAN_A_LIM_ADDR: limA   <= regWrData;
          `FTI_FAN_B_LIM_ADDR: limB   <= regWrData;
          `FTI_MASK_ADDR:      mask   <= regWrData[2:0];
          default:             ;
        endcase
      end
    end
  end

  // values and status; a read clears, a same-cycle update wins
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valA    <= 8'h00;
      valB    <= 8'h00;
      stat    <= 3'b000;
      statMir <= 3'b000;
    end else begin
      if (rdStat)
        stat <= 3'b000;
      if (doneA && state == ST_FANA) begin
        valA                     <= cntA;
        stat[`FTI_STAT_FAN_A]    <= fault(cntA, limA);
        statMir[`FTI_STAT_FAN_A] <= fault(cntA, limA);
      end
      if (doneB && state == ST_FANB) begin
        valB                     <= cntB;
        stat[`FTI_STAT_FAN_B]    <= fault(cntB, limB);
        statMir[`FTI_STAT_FAN_B] <= fault(cntB, limB);
      end
      // level input: re-set every cycle the external latch holds
      if (intrusion_pin_in && !intrusion_pin_oe) begin
        stat[`FTI_STAT_INTRUSION]    <= 1'b1;
        statMir[`FTI_STAT_INTRUSION] <= 1'b1;
      end else if (!intrusion_pin_in) begin
        statMir[`FTI_STAT_INTRUSION] <= 1'b0;
      end
    end
  end

  // self-clearing pulse timer; a rewrite during the pulse is ignored
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      iclrBit <= 1'b0;
      iclrCnt <= 32'd0;
    end else if (wrIclr && regWrData[`FTI_ICLR_BIT] && !iclrBit) begin
      iclrBit <= 1'b1;
      iclrCnt <= ICLR_CYC;
    end else if (iclrBit) begin
      if (iclrCnt == 32'd1)
        iclrBit <= 1'b0;
      iclrCnt <= iclrCnt - 32'd1;
    end
  end

  // pin drive, interrupt output and read data, all registered
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intrusion_pin_out <= 1'b0;
      intrusion_pin_oe  <= 1'b0;
      int_n             <= 1'b1;
      regRdData         <= 8'h00;
    end else begin
      intrusion_pin_out <= 1'b0;
      intrusion_pin_oe  <= iclrBit;
      // gating by enable and clear leaves status untouched
      int_n <= ~(|(stat & ~mask)
                 & cfg[`FTI_CFG_INT_EN]
                 & ~cfg[`FTI_CFG_INT_CLR]);
      regRdData <= 8'h00;
      if (regRd) begin
        case (regAddr)
          `FTI_CFG_ADDR:       regRdData <= cfg;
          `FTI_DIVID_ADDR:     regRdData <= {divSel, voltage_id_low};
          `FTI_FAN_A_VAL_ADDR: regRdData <= valA;
          `FTI_FAN_B_VAL_ADDR: regRdData <= valB;
          `FTI_FAN_A_LIM_ADDR: regRdData <= limA;
          `FTI_FAN_B_LIM_ADDR: regRdData <= limB;
          `FTI_STAT_ADDR:      regRdData <= {5'b00000, stat};
          `FTI_MASK_ADDR:      regRdData <= {5'b00000, mask};
          `FTI_INTR_CLR_ADDR:  regRdData <= {iclrBit, 7'b0000000};
          `FTI_STAT_MIR_ADDR:  regRdData <= {5'b00000, statMir};
          default:             regRdData <= 8'h00;
        endcase
      end
    end
  end

endmodule // fti_fan_monitor

// *** sim/fti_checker.sv ***
// port checker for the fan period monitor
`timescale 1ns/1ps
module fti_checker #(
  parameter [31:0] ICLR_CYC = 32'h0000_0032
) (
  // clock and reset
  input wire       core_clk,
  input wire       rst,
  // register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWr,
  // pins
  input wire       intrusion_pin_in,
  input wire       intrusion_pin_out,
  input wire       intrusion_pin_oe,
  input wire       int_n,
  input wire       analogStart
);
  reg [7:0]  cfgSh;
  reg [7:0]  mskSh;
  reg [31:0] oeCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // host write shadows, so gating is judged from ports alone
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfgSh <= 8'h00;
      mskSh <= 8'h00;
      oeCnt <= 32'h0000_0000;
    end else begin
      if (regWr && regAddr == 8'h00) cfgSh <= regWrData;
      if (regWr && regAddr == 8'h1C) mskSh <= regWrData;
      oeCnt <= intrusion_pin_oe ? oeCnt + 1 : 32'h0000_0000;
    end
  end
  sequence clrWr;
    regWr && regAddr == 8'h20 && regWrData[7];
  endsequence
  sequence pullLow;
    intrusion_pin_oe [*3];
  endsequence
  // four cycles of margin cover a pin synchroniser
  sequence intrHi;
    (intrusion_pin_in && !intrusion_pin_oe && cfgSh[1] && !cfgSh[3]
     && !mskSh[2]) [*4];
  endsequence
  oe_start_a: assert property (clrWr |-> ##[1:3] pullLow)
    else $error("clear write did not pull the pin");
  oe_len_a: assert property ($fell(intrusion_pin_oe) |->
    oeCnt == ICLR_CYC) else $error("pin pull length wrong");
  pin_low_a: assert property (!intrusion_pin_out)
    else $error("pin driven high");
  int_gate_a: assert property (!cfgSh[1] || cfgSh[3] |=> int_n)
    else $error("interrupt active while gated");
  int_mask_a: assert property (mskSh[2:0] == 3'h7 |=> int_n)
    else $error("interrupt through full mask");
  intr_int_a: assert property (intrHi |=> !int_n)
    else $error("intrusion gave no interrupt");
  astart_pulse_a: assert property (analogStart |=> !analogStart)
    else $error("analog start longer than a pulse");
  astart_run_a: assert property (analogStart |-> cfgSh[0])
    else $error("analog start without start bit");
endmodule // fti_checker

// *** sim/fti_fan_partner.sv ***
// far side: two fan tachometers and the intrusion latch
`timescale 1ns/1ps
module fti_fan_partner (
  // clock
  input  wire        core_clk,
  // fan periods in clocks
  input  wire [15:0] perA,
  input  wire [15:0] perB,
  // intrusion latch
  input  wire        intrude,
  input  wire        pinOe,
  // outputs
  output reg         tachA = 1'b0,
  output reg         tachB = 1'b0,
  output wire        pinLvl
);
  reg [15:0] cntA  = 16'h0000;
  reg [15:0] cntB  = 16'h0000;
  reg        latch = 1'b0;
  // fans spin freely, unrelated to when the device samples
  always @(posedge core_clk) begin
    cntA <= (cntA >= perA - 1) ? 16'h0000 : cntA + 1;
    cntB <= (cntB >= perB - 1) ? 16'h0000 : cntB + 1;
    tachA <= cntA < (perA >> 1);
    tachB <= cntB < (perB >> 1);
  end
  // set by a cover event, reset only by the device pulling low
  always @(posedge core_clk) begin
    if (pinOe) latch <= 1'b0;
    else if (intrude) latch <= 1'b1;
  end
  // open drain: the device pull wins over the latch
  assign pinLvl = latch & ~pinOe;
endmodule // fti_fan_partner

// *** sim/tb_fti_fan_monitor.sv ***
// testbench for the fan period monitor
`timescale 1ns/1ps
module tb_fti_fan_monitor;
  reg         core_clk  = 1'b0;
  reg         rst       = 1'b1;
  reg  [7:0]  regAddr   = 8'h00;
  reg  [7:0]  regWrData = 8'h00;
  reg         regWr     = 1'b0;
  reg         regRd     = 1'b0;
  reg  [15:0] perA      = 16'h0050;
  reg         intrude   = 1'b0;
  reg  [7:0]  d;
  wire [7:0]  regRdData;
  wire        tachA;
  wire        tachB;
  wire        pinLvl;
  wire        pinOe;
  wire        int_n;
  wire        analogStart;
  integer     errorCnt  = 0;
  integer     checks    = 0;
  always #5 core_clk = ~core_clk;
  // short counts keep the run brief
  fti_fan_monitor #(.OSC_DIV(4), .ICLR_CYC(50)) i_dut (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .tach_in_a(tachA), .tach_in_b(tachB),
    .voltage_id_low(4'hA), .intrusion_pin_in(pinLvl),
    .intrusion_pin_out(), .intrusion_pin_oe(pinOe),
    .int_n(int_n), .analogStart(analogStart));
  fti_fan_partner i_far (
    .core_clk(core_clk), .perA(perA), .perB(16'h0030),
    .intrude(intrude), .pinOe(pinOe), .tachA(tachA), .tachB(tachB),
    .pinLvl(pinLvl));
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge core_clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // range compare; exact when both bounds match
  task chk(input [7:0] g, input [7:0] lo, input [7:0] hi);
    begin
      checks = checks + 1;
      if (((g >= lo) && (g <= hi)) !== 1'b1) begin
        errorCnt = errorCnt + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, lo);
      end
    end
  endtask
  task giveVerdict;
    begin
      $display("errors=%0d checks=%0d", errorCnt, checks);
      if (errorCnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task tReset;
    begin
      rd(8'h10);
      chk(d, 8'hFF, 8'hFF);
      rd(8'h04);
      chk(d, 8'h5A, 8'h5A);
      rd(8'h1C);
      chk(d, 8'h00, 8'h00);
    end
  endtask
  // counts: 2 periods / (4 clocks * divisor), one tick of slack
  task tMeasure;
    reg seen;
    begin
      wr(8'h00, 8'h01);
      #1 seen = analogStart;
      repeat (4) begin
        @(posedge core_clk);
        #1 seen = seen | analogStart;
      end
      chk({7'h00, seen}, 8'h01, 8'h01);
      cyc(1000);
      rd(8'h08);
      chk(d, 8'h13, 8'h15);
      rd(8'h0C);
      chk(d, 8'h0B, 8'h0D);
    end
  endtask
  task tDivisor;
    begin
      wr(8'h04, 8'h60);
      cyc(800);
      rd(8'h08);
      chk(d, 8'h09, 8'h0B);
      wr(8'h04, 8'hC0);
      cyc(1200);
      rd(8'h04);
      chk(d, 8'hCA, 8'hCA);
      rd(8'h08);
      chk(d, 8'h27, 8'h29);
      rd(8'h0C);
      chk(d, 8'h02, 8'h04);
    end
  endtask
  task tStatus;
    begin
      wr(8'h10, 8'h20);
      wr(8'h00, 8'h03);
      cyc(600);
      chk({7'h00, int_n}, 8'h00, 8'h00);
      rd(8'h24);
      chk(d, 8'h01, 8'h01);
      wr(8'h1C, 8'h01);
      cyc(3);
      chk({7'h00, int_n}, 8'h01, 8'h01);
      wr(8'h1C, 8'h07);
      cyc(3);
      chk({7'h00, int_n}, 8'h01, 8'h01);
      wr(8'h1C, 8'h00);
      wr(8'h00, 8'h0B);
      cyc(3);
      chk({7'h00, int_n}, 8'h01, 8'h01);
      rd(8'h24);
      chk(d, 8'h01, 8'h01);
      wr(8'h00, 8'h00);
      rd(8'h18);
      chk(d, 8'h01, 8'h01);
      rd(8'h18);
      chk(d, 8'h00, 8'h00);
    end
  endtask
  task tSaturate;
    begin
      perA <= 16'h03E8;
      wr(8'h10, 8'hFF);
      wr(8'h00, 8'h01);
      cyc(6000);
      rd(8'h08);
      chk(d, 8'hFF, 8'hFF);
      rd(8'h24);
      chk(d, 8'h00, 8'h00);
    end
  endtask
  task tIntrude;
    begin
      @(posedge core_clk);
      intrude <= 1'b1;
      @(posedge core_clk);
      intrude <= 1'b0;
      cyc(3);
      rd(8'h24);
      chk({7'h00, d[2]}, 8'h01, 8'h01);
      wr(8'h00, 8'h03);
      cyc(20);
      chk({7'h00, int_n}, 8'h00, 8'h00);
      wr(8'h20, 8'h80);
      cyc(3);
      chk({7'h00, pinOe}, 8'h01, 8'h01);
      rd(8'h20);
      chk({7'h00, d[7]}, 8'h01, 8'h01);
      cyc(60);
      rd(8'h20);
      chk({7'h00, d[7]}, 8'h00, 8'h00);
      chk({6'h00, pinOe, pinLvl}, 8'h00, 8'h00);
      rd(8'h18);
      cyc(3);
      rd(8'h18);
      chk(d, 8'h00, 8'h00);
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    tReset;
    tMeasure;
    tDivisor;
    tStatus;
    tSaturate;
    tIntrude;
    giveVerdict;
  end
  // watchdog: the whole sequence needs about 10000 cycles
  initial begin
    #500000;
    errorCnt = errorCnt + 1;
    giveVerdict;
  end
endmodule // tb_fti_fan_monitor
bind fti_fan_monitor fti_checker #(.ICLR_CYC(ICLR_CYC)) i_chk (
  .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr),
  .intrusion_pin_in(intrusion_pin_in),
  .intrusion_pin_out(intrusion_pin_out),
  .intrusion_pin_oe(intrusion_pin_oe), .int_n(int_n),
  .analogStart(analogStart));
